// *** src/via_pkg.sv ***
// Package for the vectored interrupt arbiter: register map, field layout, constants, carriers
package via_pkg;
    localparam int VIA_NSRC = 26;
    localparam int VIA_NGRP = 4;
    localparam int VIA_NSLOT = 6;
    // Register byte offsets
    localparam logic [7:0] VIA_OFF_CONTROL = 8'h00;
    localparam logic [7:0] VIA_OFF_MODE = 8'h04;
    localparam logic [7:0] VIA_OFF_PENDING = 8'h08;
    localparam logic [7:0] VIA_OFF_MASK = 8'h0c;
    localparam logic [7:0] VIA_OFF_NORMAL_CLR = 8'h10;
    localparam logic [7:0] VIA_OFF_FAST_CLR = 8'h14;
    localparam logic [7:0] VIA_OFF_SLAVE_PRIO = 8'h18;
    localparam logic [7:0] VIA_OFF_MASTER_PRIO = 8'h1c;
    localparam logic [7:0] VIA_OFF_EVT_STATUS = 8'h20;
    localparam logic [7:0] VIA_OFF_EVT_MASK = 8'h24;
    localparam logic [7:0] VIA_OFF_WINNER = 8'h28;
    // Control fields
    localparam int VIA_CTL_VECTORED = 0;
    localparam int VIA_CTL_RR_SLAVE = 1;
    localparam int VIA_CTL_RR_MASTER = 2;
    // Mask register: bit 26 is the global mask
    localparam int VIA_MASK_GLOBAL = 26;
    localparam logic [31:0] VIA_CONTROL_RST = 32'h0000_0000;
    localparam logic [26:0] VIA_MASK_RST = 27'h7ff_ffff;
    localparam logic [7:0] VIA_PRIO_RST = 8'he4;
    // Vector fetch
    localparam logic [31:0] VIA_IRQ_VECTOR = 32'h0000_0018;
    localparam logic [31:0] VIA_FIQ_VECTOR = 32'h0000_001c;
    localparam logic [31:0] VIA_BRANCH_BASE = 32'hea00_0000;
    localparam logic [31:0] VIA_VEC_FIRST = 32'h0000_0020;
    localparam logic [31:0] VIA_PIPE_OFS = 32'h0000_0008;
    localparam logic [31:0] VIA_VEC_GROUP_STEP = 32'h0000_0020;
    localparam logic [31:0] VIA_VEC_DIRECT_FIRST = 32'h0000_00a0;
    localparam logic [31:0] VIA_VEC_DIRECT_SECOND = 32'h0000_00c0;
    localparam logic [1:0] VIA_RESP_OKAY = 2'b00;
    localparam logic [1:0] VIA_RESP_SLVERR = 2'b10;

    typedef struct packed {
        logic [31:0] addr;
        logic fetch;
    } via_fetch_t;

    typedef struct packed {
        logic valid;
        logic [4:0] index;
    } via_winner_t;
endpackage

// *** src/via_arbiter.sv ***
// Vectored interrupt arbiter with AXI4-Lite registers and vector fetch port
//
// Functional notes
// RULE1 - Thirty raw requests: external pins and peripheral lines enter the controller.
// RULE2 - Upper four external pins are ORed into one request input.
// RULE3 - Both serial error lines are ORed into one shared request.
// RULE4 - Arbitrate simultaneous requests, then assert fast or normal request line.
// RULE5 - Pending register shows every requesting source for software-ordered service.
// RULE6 - Vectored mode: priority logic picks winner, supplies jump at 0x18 or 0x1c. Only the 0x18 fetch is answered here; 0x1c gets no jump.
// RULE7 - Each source individually selects fast or normal request type.
// RULE8 - Pending register flags outstanding requests and is read-only.
// RULE9 - Software writes one to a pending-clear port bit; device drops flag.
// RULE10 - Mask bit zero forwards a source; mask bit one blocks it.
// RULE11 - A masked source still sets its pending flag.
// RULE12 - Global mask one: pending still set, nothing delivered to core.
// RULE13 - Normal priority uses four six-source slave units and one master unit.
// RULE14 - Slave: four programmable slots above two fixed; first fixed beats second.
// RULE15 - Master: four groups above two direct sources; first direct beats second.
// RULE16 - Vectored normal fetch at 0x18 returns branch from 0xea000000 to winner's vector.
// RULE17 - Zero bits written to pending-clear ports leave flags unchanged.
//
// Design decisions made here: the address map and the AXI4-Lite register port.
`timescale 1ns/1ps
module via_arbiter
    import via_pkg::*;
(
    input wire logic clk,
    input wire logic arst_n,
    input wire logic [7:0] ext_req,
    input wire logic [19:0] periph_req,
    input wire logic [1:0] serial_err_req,
    input wire via_fetch_t fetch,
    output logic [31:0] fetch_data,
    output logic fetch_data_valid,
    output logic irq_req,
    output logic fiq_req,
    output logic evt_irq,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    // ----------------------------------------
    // Input synchronisers and source merge
    // ----------------------------------------
    logic [29:0] sync1, sync2;
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            sync1 <= 30'h0000_0000;
            sync2 <= 30'h0000_0000;
        end else begin
            sync1 <= {serial_err_req, periph_req, ext_req}; // [RULE1]
            sync2 <= sync1;
        end
    end
    wire [7:0] ext_s = sync2[7:0];
    wire [19:0] per_s = sync2[27:8];
    wire [1:0] err_s = sync2[29:28];
    wire merged_external_request = |ext_s[7:4]; // [RULE2]
    wire merged_serial_error_request = |err_s; // [RULE3]
    // Source index = group*6 + slot; 24 = first direct, 25 = second direct.
    // periph_req order: tick,zdma0,zdma1,bdma0,bdma1,wdt,timer0..5,urxd0,urxd1,iic,sio,utxd0,utxd1,rtc,adc
    wire [VIA_NSRC-1:0] src = {per_s[19:6], merged_serial_error_request, per_s[5:1],
                               per_s[0], merged_external_request, ext_s[3:0]};

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    logic [31:0] control;
    logic [VIA_NSRC-1:0] mode_fast, pending, src_d;
    logic [VIA_NSRC:0] source_mask_register;
    logic [7:0] slave_prio [VIA_NGRP];
    logic [7:0] master_prio;
    logic [2:0] evt_status, evt_mask;

    // ----------------------------------------
    // AXI4-Lite slave
    // ----------------------------------------
    logic aw_held, w_held;
    logic [7:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    wire aw_take = s_axi_awvalid && s_axi_awready;
    wire w_take = s_axi_wvalid && s_axi_wready;
    wire wr_go = aw_held && w_held && !s_axi_bvalid;
    wire next_aw_held = !wr_go && (aw_held || aw_take);
    wire next_w_held = !wr_go && (w_held || w_take);
    wire next_bvalid = wr_go || (s_axi_bvalid && !s_axi_bready);
    wire [31:0] wmask = {{8{w_strb[3]}}, {8{w_strb[2]}}, {8{w_strb[1]}}, {8{w_strb[0]}}};
    wire [31:0] wbits = w_data & wmask;
    wire sel_ctl = wr_go && aw_addr == VIA_OFF_CONTROL;
    wire sel_mode = wr_go && aw_addr == VIA_OFF_MODE;
    wire sel_mask = wr_go && aw_addr == VIA_OFF_MASK;
    wire sel_nclr = wr_go && aw_addr == VIA_OFF_NORMAL_CLR;
    wire sel_fclr = wr_go && aw_addr == VIA_OFF_FAST_CLR;
    wire sel_sp = wr_go && aw_addr == VIA_OFF_SLAVE_PRIO;
    wire sel_mp = wr_go && aw_addr == VIA_OFF_MASTER_PRIO;
    wire sel_es = wr_go && aw_addr == VIA_OFF_EVT_STATUS;
    wire sel_em = wr_go && aw_addr == VIA_OFF_EVT_MASK;
    // Pending is read-only, so its offset is not a legal write target
    wire wr_ok = sel_ctl | sel_mode | sel_mask | sel_nclr | sel_fclr | sel_sp | sel_mp | sel_es | sel_em; // [RULE8]

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= 8'h00;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= VIA_RESP_OKAY;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
        end else begin
            aw_held <= next_aw_held;
            w_held <= next_w_held;
            s_axi_bvalid <= next_bvalid;
            // Ready flops follow the next held state, so timing matches a decoded ready
            s_axi_awready <= !next_aw_held && !next_bvalid;
            s_axi_wready <= !next_w_held && !next_bvalid;
            if (aw_take) begin
                aw_addr <= {s_axi_awaddr[7:2], 2'b00};
            end
            if (w_take) begin
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
            if (wr_go) begin
                s_axi_bresp <= wr_ok ? VIA_RESP_OKAY : VIA_RESP_SLVERR;
            end
        end
    end

    // ----------------------------------------
    // Priority arbitration for normal requests
    // ----------------------------------------
    wire global_mask = source_mask_register[VIA_MASK_GLOBAL];
    wire [VIA_NSRC-1:0] deliver = pending & ~source_mask_register[VIA_NSRC-1:0] & {VIA_NSRC{!global_mask}}; // [RULE10] [RULE12]
    wire [VIA_NSRC-1:0] irq_cand = deliver & ~mode_fast; // [RULE7]
    logic [VIA_NGRP-1:0] grp_hit;
    logic [2:0] grp_win [VIA_NGRP];
    logic [1:0] slv_last [VIA_NGRP];

    // Pick the programmable slot whose rank order (4x2-bit, highest first) hits first
    function automatic logic [2:0] via_rank4(input logic [3:0] req, input logic [7:0] order);
        logic [2:0] res;
        res = 3'h4;
        for (int k = 3; k >= 0; k--) begin
            if (res == 3'h4 && req[order[2*k +: 2]]) begin
                res = {1'b0, order[2*k +: 2]};
            end
        end
        return res;
    endfunction

    // Rotate order so that the slot after the last winner ranks first
    function automatic logic [7:0] via_rr(input logic [1:0] last);
        logic [1:0] a;
        a = last + 2'd1;
        return {a, 2'(a + 2'd1), 2'(a + 2'd2), 2'(a + 2'd3)};
    endfunction

    genvar g;
    generate
        for (g = 0; g < VIA_NGRP; g++) begin : g_slave // [RULE13]
            wire [5:0] req = irq_cand[g*VIA_NSLOT +: VIA_NSLOT];
            wire [7:0] ord = control[VIA_CTL_RR_SLAVE] ? via_rr(slv_last[g]) : slave_prio[g];
            wire [2:0] prog = via_rank4(req[3:0], ord);
            assign grp_hit[g] = |req;
            // Programmable slots outrank both fixed slots; first fixed beats second
            assign grp_win[g] = !prog[2] ? prog : (req[4] ? 3'd4 : 3'd5); // [RULE14]
        end
    endgenerate

    logic [1:0] mst_last;
    wire [7:0] mord = control[VIA_CTL_RR_MASTER] ? via_rr(mst_last) : master_prio;
    wire [2:0] mprog = via_rank4(grp_hit, mord);
    via_winner_t next_win;
    always_comb begin
        next_win = '{valid: 1'b0, index: 5'd0};
        if (!mprog[2]) begin
            next_win = '{valid: 1'b1, index: 5'(mprog[1:0] * 3'd6 + grp_win[mprog[1:0]])};
        end else if (irq_cand[24]) begin
            next_win = '{valid: 1'b1, index: 5'd24}; // [RULE15]
        end else if (irq_cand[25]) begin
            next_win = '{valid: 1'b1, index: 5'd25};
        end
    end

    // Vector address: groups at 0x20 step 0x20, slots 4 bytes apart, directs fixed
    wire [31:0] vec_addr = next_win.index == 5'd24 ? VIA_VEC_DIRECT_FIRST :
                           next_win.index == 5'd25 ? VIA_VEC_DIRECT_SECOND :
                           VIA_VEC_FIRST + VIA_VEC_GROUP_STEP * 32'(next_win.index / 5'd6)
                           + 32'(next_win.index % 5'd6) * 32'd4;
    wire [31:0] offs = (vec_addr - VIA_IRQ_VECTOR - VIA_PIPE_OFS) >> 2;
    wire [31:0] branch = VIA_BRANCH_BASE + {8'h00, offs[23:0]}; // [RULE16]
    wire vec_hit = control[VIA_CTL_VECTORED] && fetch.fetch && fetch.addr == VIA_IRQ_VECTOR && next_win.valid;
    wire [VIA_NSRC-1:0] rise = src & ~src_d;

    // ----------------------------------------
    // Register state, pending and outputs
    // ----------------------------------------
    wire [VIA_NSRC-1:0] nclr = sel_nclr ? wbits[VIA_NSRC-1:0] & ~mode_fast : '0; // [RULE17]
    wire [VIA_NSRC-1:0] fclr = sel_fclr ? wbits[VIA_NSRC-1:0] & mode_fast : '0;
    // A fresh edge wins over a clear in the same cycle
    wire [VIA_NSRC-1:0] next_pending = (pending & ~(nclr | fclr)) | rise; // [RULE9] [RULE11] [RULE5]
    wire [2:0] evt_set = {vec_hit, |(deliver & mode_fast), |rise};
    wire [2:0] next_evt_status = (evt_status & ~(sel_es ? w_data[2:0] : 3'h0)) | evt_set;
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            control <= VIA_CONTROL_RST;
            mode_fast <= '0;
            pending <= '0;
            src_d <= '0;
            source_mask_register <= VIA_MASK_RST;
            master_prio <= VIA_PRIO_RST;
            mst_last <= 2'd3;
            evt_status <= 3'h0;
            evt_mask <= 3'h0;
            irq_req <= 1'b0;
            fiq_req <= 1'b0;
            evt_irq <= 1'b0;
            fetch_data <= 32'h0000_0000;
            fetch_data_valid <= 1'b0;
        end else begin
            src_d <= src;
            pending <= next_pending;
            if (sel_ctl) control <= (control & ~wmask) | wbits;
            if (sel_mode) mode_fast <= (mode_fast & ~wmask[VIA_NSRC-1:0]) | wbits[VIA_NSRC-1:0]; // [RULE7]
            if (sel_mask) source_mask_register <= (source_mask_register & ~wmask[VIA_NSRC:0]) | wbits[VIA_NSRC:0];
            if (sel_mp) master_prio <= w_data[7:0];
            if (sel_em) evt_mask <= w_data[2:0];
            evt_status <= next_evt_status;
            irq_req <= |irq_cand; // [RULE4]
            fiq_req <= |(deliver & mode_fast); // [RULE4]
            evt_irq <= |(next_evt_status & evt_mask);
            fetch_data_valid <= vec_hit;
            fetch_data <= vec_hit ? branch : 32'h0000_0000; // [RULE6]
            if (vec_hit && !mprog[2]) begin
                mst_last <= mprog[1:0];
            end
        end
    end
    generate
        for (g = 0; g < VIA_NGRP; g++) begin : g_slv_state
            always_ff @(posedge clk or negedge arst_n) begin
                if (!arst_n) begin
                    slave_prio[g] <= VIA_PRIO_RST;
                    slv_last[g] <= 2'd3;
                end else begin
                    if (sel_sp && w_strb[g]) slave_prio[g] <= w_data[8*g +: 8];
                    if (vec_hit && !mprog[2] && mprog[1:0] == 2'(g) && !grp_win[g][2]) begin
                        slv_last[g] <= grp_win[g][1:0];
                    end
                end
            end
        end
    endgenerate

    // ----------------------------------------
    // Read path
    // ----------------------------------------
    wire [7:0] ra = {s_axi_araddr[7:2], 2'b00};
    wire rd_ok = ra <= VIA_OFF_WINNER;
    wire [31:0] rmux =
        ra == VIA_OFF_CONTROL ? control :
        ra == VIA_OFF_MODE ? 32'(mode_fast) :
        ra == VIA_OFF_PENDING ? 32'(pending) :
        ra == VIA_OFF_MASK ? 32'(source_mask_register) :
        ra == VIA_OFF_SLAVE_PRIO ? {slave_prio[3], slave_prio[2], slave_prio[1], slave_prio[0]} :
        ra == VIA_OFF_MASTER_PRIO ? 32'(master_prio) :
        ra == VIA_OFF_EVT_STATUS ? 32'(evt_status) :
        ra == VIA_OFF_EVT_MASK ? 32'(evt_mask) :
        ra == VIA_OFF_WINNER ? 32'({next_win.valid, next_win.index}) : 32'h0000_0000;
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= VIA_RESP_OKAY;
            s_axi_arready <= 1'b1;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_arready <= 1'b0;
            s_axi_rdata <= rd_ok ? rmux : 32'h0000_0000;
            s_axi_rresp <= rd_ok ? VIA_RESP_OKAY : VIA_RESP_SLVERR;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end
endmodule

// *** tb/via_arbiter_props.sv ***
// Concurrent checks on the arbiter's bus and vector fetch ports
`timescale 1ns/1ps
module via_arbiter_props
    import via_pkg::*;
(
    input wire logic clk,
    input wire logic arst_n,
    input wire via_fetch_t fetch,
    input wire logic [31:0] fetch_data,
    input wire logic fetch_data_valid,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    logic wr_take;
    logic rd_take;
    assign wr_take = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    assign rd_take = s_axi_arvalid && s_axi_arready;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!arst_n);
    a_b_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped early");
    a_r_holds: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped early");
    a_wr_answer: assert property (wr_take |-> ##2 s_axi_bvalid) else $error("write answer late");
    a_rd_answer: assert property (rd_take |=> s_axi_rvalid) else $error("read answer late");
    a_wr_blocked: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready) else $error("write taken early");
    a_rd_blocked: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("read taken early");
    a_pend_ro: assert property (wr_take && s_axi_awaddr == VIA_OFF_PENDING |-> ##2 s_axi_bresp == VIA_RESP_SLVERR)
        else $error("pending write accepted");
    a_rd_unmapped: assert property (rd_take && s_axi_araddr[7:2] > 6'h0a |=> s_axi_rresp == VIA_RESP_SLVERR && s_axi_rdata == 32'h0)
        else $error("unmapped read answered");
    a_fetch_cause: assert property (fetch_data_valid |-> $past(fetch.fetch) && $past(fetch.addr) == VIA_IRQ_VECTOR)
        else $error("branch word without fetch");
    a_branch_op: assert property (fetch_data_valid |-> fetch_data[31:16] == 16'hea00)
        else $error("branch word malformed");
endmodule
bind via_arbiter via_arbiter_props u_props (.clk, .arst_n, .fetch, .fetch_data, .fetch_data_valid, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);

// *** tb/via_core_model.sv ***
// Behavioural core that fetches the normal vector when asked
`timescale 1ns/1ps
module via_core_model
    import via_pkg::*;
(
    input wire logic clk,
    input wire logic arst_n,
    input wire logic go,
    input wire logic irq_req,
    input wire logic [31:0] fetch_data,
    input wire logic fetch_data_valid,
    output via_fetch_t fetch,
    output logic [31:0] word,
    output logic got
);
    logic busy;
    logic start;
    // One fetch per go pulse; the core only enters the vector while a request is up
    assign start = go && irq_req && !busy;
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            fetch <= '0;
            busy <= 1'b0;
            word <= 32'h0;
            got <= 1'b0;
        end else begin
            busy <= go && (busy || start);
            got <= fetch_data_valid;
            fetch.fetch <= start;
            // Idle address toggles so a stale vector cannot pass for a fetch
            fetch.addr <= start ? VIA_IRQ_VECTOR : ~fetch.addr;
            if (fetch_data_valid) word <= fetch_data;
        end
    end
endmodule

// *** tb/via_arbiter_tb.sv ***
// Self-checking bench for the vectored interrupt arbiter
`timescale 1ns/1ps
module via_arbiter_tb
    import via_pkg::*;
;
    logic clk, arst_n, go, got, fetch_data_valid, irq_req, fiq_req, evt_irq;
    logic [7:0] ext_req, s_axi_awaddr, s_axi_araddr;
    logic [19:0] periph_req;
    logic [1:0] serial_err_req, s_axi_bresp, s_axi_rresp, wr_resp;
    via_fetch_t fetch;
    logic [31:0] fetch_data, word, s_axi_wdata, s_axi_rdata;
    logic [3:0] s_axi_wstrb;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    int bad_count, num_checks;
    via_arbiter dut (.clk, .arst_n, .ext_req, .periph_req, .serial_err_req, .fetch, .fetch_data, .fetch_data_valid,
        .irq_req, .fiq_req, .evt_irq, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
    via_core_model core (.clk, .arst_n, .go, .irq_req, .fetch_data, .fetch_data_valid, .fetch, .word, .got);
    // ----------------------------------------
    // Bus tasks
    // ----------------------------------------
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] seen);
        num_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
        do begin
            @(posedge clk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        wr_resp = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask
    task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] e);
        @(posedge clk);
        s_axi_araddr <= a;
        {s_axi_arvalid, s_axi_rready} <= 2'h3;
        do begin
            @(posedge clk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        s_axi_rready <= 1'b0;
        chk(nm, e, s_axi_rdata);
    endtask
    task automatic vec(input logic [31:0] e);
        @(posedge clk);
        go <= 1'b1;
        do @(posedge clk); while (!got);
        go <= 1'b0;
        chk("branch word", e, word);
    endtask
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    // Tests take well under a thousand cycles
    initial begin
        repeat (5000) @(posedge clk);
        bad_count++;
        tally_and_finish();
    end
    // ----------------------------------------
    // Tests
    // ----------------------------------------
    initial begin
        {arst_n, go, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        {ext_req, periph_req, serial_err_req, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        s_axi_wstrb = 4'hf;
        bad_count = 0;
        num_checks = 0;
        repeat (12) @(posedge clk);
        arst_n <= 1'b1;
        rdc("mask reset", VIA_OFF_MASK, {5'h0, VIA_MASK_RST});
        rdc("pending reset", VIA_OFF_PENDING, 32'h0);
        rdc("unmapped", 8'h40, 32'h0);
        $display("test reset done");
        ext_req <= 8'h20;
        serial_err_req <= 2'b10;
        repeat (6) @(posedge clk);
        rdc("pending merged", VIA_OFF_PENDING, 32'h810);
        chk("irq masked", 0, irq_req);
        wr(VIA_OFF_PENDING, 32'h0);
        chk("pending write resp", VIA_RESP_SLVERR, wr_resp);
        rdc("pending kept", VIA_OFF_PENDING, 32'h810);
        wr(VIA_OFF_NORMAL_CLR, 32'h0);
        rdc("clear zero", VIA_OFF_PENDING, 32'h810);
        wr(VIA_OFF_NORMAL_CLR, 32'h810);
        rdc("clear one", VIA_OFF_PENDING, 32'h0);
        $display("test pending done");
        wr(VIA_OFF_EVT_STATUS, 32'h7);
        wr(VIA_OFF_EVT_MASK, 32'h1);
        wr(VIA_OFF_MASK, 32'h03ff_fffe);
        chk("event idle", 0, evt_irq);
        ext_req <= 8'h01;
        repeat (6) @(posedge clk);
        chk("irq delivered", 1, irq_req);
        chk("event irq", 1, evt_irq);
        wr(VIA_OFF_EVT_STATUS, 32'h1);
        repeat (2) @(posedge clk);
        chk("event cleared", 0, evt_irq);
        wr(VIA_OFF_MASK, 32'h07ff_fffc);
        ext_req <= 8'h03;
        repeat (6) @(posedge clk);
        chk("irq global", 0, irq_req);
        rdc("pending global", VIA_OFF_PENDING, 32'h3);
        wr(VIA_OFF_MASK, 32'h03ff_fffc);
        wr(VIA_OFF_MODE, 32'h3);
        repeat (2) @(posedge clk);
        chk("fiq", 1, fiq_req);
        chk("irq idle", 0, irq_req);
        wr(VIA_OFF_FAST_CLR, 32'h3);
        repeat (2) @(posedge clk);
        chk("fiq cleared", 0, fiq_req);
        wr(VIA_OFF_MODE, 32'h0);
        ext_req <= 8'h00;
        $display("test delivery done");
        repeat (6) @(posedge clk);
        ext_req <= 8'h11;
        wr(VIA_OFF_MASK, 32'h03ff_ffee);
        wr(VIA_OFF_CONTROL, 32'h1);
        repeat (6) @(posedge clk);
        vec(VIA_BRANCH_BASE);
        wr(VIA_OFF_NORMAL_CLR, 32'h1);
        vec(VIA_BRANCH_BASE + 32'h4);
        $display("test vector done");
        wr(VIA_OFF_NORMAL_CLR, 32'h10);
        wr(VIA_OFF_MASK, 32'h00ff_cfdf);
        periph_req <= 20'hc_00c1;
        repeat (6) @(posedge clk);
        rdc("winner slave order", VIA_OFF_WINNER, 32'h2d);
        wr(VIA_OFF_CONTROL, 32'h3);
        vec(VIA_BRANCH_BASE + 32'h10);
        vec(VIA_BRANCH_BASE + 32'h11);
        rdc("winner round robin", VIA_OFF_WINNER, 32'h2c);
        wr(VIA_OFF_CONTROL, 32'h1);
        wr(VIA_OFF_MASTER_PRIO, 32'h1b);
        rdc("winner master order", VIA_OFF_WINNER, 32'h25);
        wr(VIA_OFF_NORMAL_CLR, 32'h3020);
        rdc("winner direct first", VIA_OFF_WINNER, 32'h38);
        vec(VIA_BRANCH_BASE + 32'h20);
        wr(VIA_OFF_NORMAL_CLR, 32'h0100_0000);
        rdc("winner direct second", VIA_OFF_WINNER, 32'h39);
        $display("test priority done");
        tally_and_finish();
    end
endmodule
